// [hdl/srs_map.vh]
// Constants and rule summary for the subsystem reset sequencer.
// Operation
// - Processing system and programmable logic resets assert independently.
// - Processing-system-only reset reboots processing system; logic stays running.
// - Processing-system-only reset starts from hardware errors or software request.
// - An error-caused processing-system-only reset may flag the programmable logic.
// - Such errors reach the platform manager, which raises its logic error output.
// - No processing-system-only reset in 24-bit quad boot with flash over 16 MB.
// - Each application core has its own reset.
// - Cluster reset from domain, watchdog or software; no drain first.
// - No application-only reset in 24-bit quad boot above 16/32 MB.
// - Realtime cores reset separately; in lockstep core zero resets both.
// - Realtime reset from errors, lockstep mismatch or software request.
// - Realtime core bus traffic drains before its reset.
// - Full-power-domain reset covers whole domain; from errors or software.
// - Error-caused domain reset is flagged to low power domain and logic.
// - Domain traffic drains before reset; release follows power-up order.
// - Manager outputs and extended pins serve as logic resets.
// - Subsystem restart drains traffic and blocks new traffic before reset.
// - Subsystem restart leaves other subsystems running.
// - Processor held in reset until clean reset-vector code confirmed.
// - On-chip RAM is 256 KB starting at 0xfffc0000.
`ifndef SRS_MAP_VH
`define SRS_MAP_VH
// On-chip RAM placement, kept for software layout checks.
`define SRS_OCM_BASE 32'hfffc0000
`define SRS_OCM_SIZE 32'h00040000
`define SRS_FLASH_SINGLE_MAX_MB 16'h0010
`define SRS_FLASH_DUAL_MAX_MB 16'h0020
`define SRS_HOLD_NS 200
`define SRS_CLK_NS 25
`define SRS_HOLD_CYC ((`SRS_HOLD_NS + `SRS_CLK_NS - 1) / `SRS_CLK_NS)
`define SRS_TGT_PS 3'h0
`define SRS_TGT_FPD 3'h1
`define SRS_TGT_APU 3'h2
`define SRS_TGT_RPU0 3'h3
`define SRS_TGT_RPU1 3'h4
`define SRS_TGT_ACORE 3'h5
`endif

// [hdl/srs_sync.v]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module srs_sync #(
  parameter W = 1
) (
  input wire core_clk,
  input wire reset_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit changes only once the second and third stages agree.
      sync_out <= (s2_r & s3_r) | (sync_out & (s2_r | s3_r));
    end
  end
endmodule // srs_sync

// [hdl/srs_hold.v]
// Minimum reset hold counter started by a pulse.
`timescale 1ns/1ps
`include "srs_map.vh"
module srs_hold (
  input wire core_clk,
  input wire reset_n,
  input wire start,
  output reg busy
);
  // The count is cut to the counter width on purpose; it stays below 256.
  localparam [31:0] HOLD_FULL = `SRS_HOLD_CYC - 1;
  localparam [7:0] HOLD_LOAD = HOLD_FULL[7:0];
  reg [7:0] cnt_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
      busy <= 1'b0;
    end else if (start) begin
      cnt_r <= HOLD_LOAD;
      busy <= 1'b1;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule // srs_hold

// [hdl/srs_sequencer.v]
// Subsystem reset sequencer: drain, assert, hold, verify, ordered release.
`timescale 1ns/1ps
`include "srs_map.vh"
module srs_sequencer (
  input wire core_clk,
  input wire reset_n,
  input wire reqValid,
  input wire [2:0] reqTarget,
  input wire [3:0] reqCoreMask,
  input wire [5:0] errIn,
  input wire lockstepErr,
  input wire lockstepMode,
  input wire watchdogTimeout,
  input wire quadSerial24Boot,
  input wire dualParallel,
  input wire [15:0] flashSizeMb,
  input wire drainDone,
  input wire vectorOk,
  input wire [3:0] plResetReq,
  output reg reqBusy,
  output reg reqRefused,
  output reg drainReq,
  output reg blockNewTxn,
  output reg psResetN,
  output reg fpdResetN,
  output reg [3:0] apuCoreResetN,
  output reg [1:0] rpuCoreResetN,
  output reg [3:0] plResetN,
  output reg platformErrToPl,
  output reg errToLpd
);
  // --------------------------------------------------------------
  // States
  // --------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DRAIN = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_VECT = 3'h3;
  localparam [2:0] ST_REL1 = 3'h4;
  localparam [2:0] ST_REL2 = 3'h5;

  reg [2:0] state_r;
  reg [2:0] tgt_r;
  reg [3:0] mask_r;
  reg fromErr_r;
  wire [5:0] errS;
  wire lockErrS;
  wire wdS;
  wire [3:0] plReqS;
  wire holdBusy;
  reg holdStart;
  reg [5:0] errPrev_r;
  reg lockPrev_r;
  reg wdPrev_r;

  // --------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------
  srs_sync #(.W(6)) uErr (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(errIn),
    .sync_out(errS)
  );
  srs_sync #(.W(6)) uMisc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({lockstepErr, watchdogTimeout, plResetReq}),
    .sync_out({lockErrS, wdS, plReqS})
  );
  srs_hold uHold (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(holdStart),
    .busy(holdBusy)
  );

  // True when the boot setup forbids a given reset kind.
  function blocked;
    input [2:0] t;
    input q24;
    input dual;
    input [15:0] mb;
    begin
      blocked = 1'b0;
      if (q24 && t == `SRS_TGT_PS && mb > `SRS_FLASH_SINGLE_MAX_MB)
        blocked = 1'b1;
      if (q24 && t == `SRS_TGT_APU) begin
        if (!dual && mb > `SRS_FLASH_SINGLE_MAX_MB)
          blocked = 1'b1;
        if (dual && mb > `SRS_FLASH_DUAL_MAX_MB)
          blocked = 1'b1;
      end
    end
  endfunction

  // --------------------------------------------------------------
  // Target decode
  // --------------------------------------------------------------
  // Targets whose sequence ends by letting the realtime cores go.
  function relRt;
    input [2:0] t;
    begin
      relRt = (t == `SRS_TGT_PS) || (t == `SRS_TGT_RPU0) ||
              (t == `SRS_TGT_RPU1);
    end
  endfunction

  // Targets whose sequence ends by letting every application core go.
  function relApp;
    input [2:0] t;
    begin
      relApp = (t == `SRS_TGT_PS) || (t == `SRS_TGT_FPD) ||
               (t == `SRS_TGT_APU);
    end
  endfunction

  // Application resets are for debug and hang recovery, so they do not
  // wait for the interconnect; a hung cluster may never drain.
  function skipDrain;
    input [2:0] t;
    begin
      skipDrain = (t == `SRS_TGT_APU) || (t == `SRS_TGT_ACORE);
    end
  endfunction

  // --------------------------------------------------------------
  // Event decode
  // --------------------------------------------------------------
  // Errors: bits 1:0 processing system, 3:2 full domain, 5:4 realtime.
  wire [5:0] errRise = errS & ~errPrev_r;
  wire lockRise = lockErrS & ~lockPrev_r;
  wire wdRise = wdS & ~wdPrev_r;
  wire psErr = |errRise[1:0];
  wire fpdErr = |errRise[3:2];
  wire rpuErr = |errRise[5:4] | lockRise;

  reg evGo;
  reg [2:0] evTgt;
  reg [3:0] evMask;
  reg evErr;
  always @* begin
    evGo = 1'b1;
    evErr = 1'b1;
    evMask = 4'h0;
    evTgt = `SRS_TGT_PS;
    if (psErr) begin
      evTgt = `SRS_TGT_PS;
    end else if (fpdErr) begin
      evTgt = `SRS_TGT_FPD;
    end else if (rpuErr) begin
      evTgt = `SRS_TGT_RPU0;
    end else if (wdRise) begin
      evTgt = `SRS_TGT_APU;
      evErr = 1'b0;
    end else if (reqValid) begin
      evTgt = reqTarget;
      evMask = reqCoreMask;
      evErr = 1'b0;
    end else begin
      evGo = 1'b0;
      evErr = 1'b0;
    end
  end

  // Cluster and single-core application resets skip the drain.
  wire evNoDrain = skipDrain(evTgt);
  wire evBlocked = blocked(evTgt, quadSerial24Boot, dualParallel,
                           flashSizeMb);
  wire tgtPs = tgt_r == `SRS_TGT_PS;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      tgt_r <= `SRS_TGT_PS;
      mask_r <= 4'h0;
      fromErr_r <= 1'b0;
      errPrev_r <= 6'h00;
      lockPrev_r <= 1'b0;
      wdPrev_r <= 1'b0;
      holdStart <= 1'b0;
      reqBusy <= 1'b0;
      reqRefused <= 1'b0;
      drainReq <= 1'b0;
      blockNewTxn <= 1'b0;
      psResetN <= 1'b0;
      fpdResetN <= 1'b0;
      apuCoreResetN <= 4'h0;
      rpuCoreResetN <= 2'h0;
      plResetN <= 4'h0;
      platformErrToPl <= 1'b0;
      errToLpd <= 1'b0;
    end else begin
      errPrev_r <= errS;
      lockPrev_r <= lockErrS;
      wdPrev_r <= wdS;
      holdStart <= 1'b0;
      reqRefused <= 1'b0;
      // Logic resets follow only their own requests.
      plResetN <= ~plReqS;
      case (state_r)
        ST_IDLE: begin
          // After power-on all domains come out through the release path.
          if (!psResetN) begin
            state_r <= ST_VECT;
            tgt_r <= `SRS_TGT_PS;
            reqBusy <= 1'b1;
          end else if (evGo && evBlocked) begin
            reqRefused <= 1'b1;
          end else if (evGo) begin
            tgt_r <= evTgt;
            mask_r <= evMask;
            fromErr_r <= evErr;
            reqBusy <= 1'b1;
            if (evErr && evTgt == `SRS_TGT_PS)
              platformErrToPl <= 1'b1;
            if (evErr && evTgt == `SRS_TGT_FPD) begin
              platformErrToPl <= 1'b1;
              errToLpd <= 1'b1;
            end
            if (evNoDrain) begin
              state_r <= ST_HOLD;
              holdStart <= 1'b1;
              if (evTgt == `SRS_TGT_APU)
                apuCoreResetN <= 4'h0;
              else
                apuCoreResetN <= apuCoreResetN & ~evMask;
            end else begin
              state_r <= ST_DRAIN;
              drainReq <= 1'b1;
              blockNewTxn <= 1'b1;
            end
          end
        end
        ST_DRAIN: begin
          // Resets fall only once the interconnect reports the drain done.
          if (drainDone) begin
            drainReq <= 1'b0;
            state_r <= ST_HOLD;
            holdStart <= 1'b1;
            // Only the target's resets fall here.
            case (tgt_r)
              `SRS_TGT_PS: begin
                psResetN <= 1'b0;
                fpdResetN <= 1'b0;
                apuCoreResetN <= 4'h0;
                rpuCoreResetN <= 2'h0;
              end
              `SRS_TGT_FPD: begin
                fpdResetN <= 1'b0;
                apuCoreResetN <= 4'h0;
              end
              `SRS_TGT_RPU0: begin
                rpuCoreResetN[0] <= 1'b0;
                if (lockstepMode)
                  rpuCoreResetN[1] <= 1'b0;
              end
              `SRS_TGT_RPU1: begin
                rpuCoreResetN[1] <= 1'b0;
              end
              default: begin
                fpdResetN <= fpdResetN;
              end
            endcase
          end
        end
        ST_HOLD: begin
          if (!holdStart && !holdBusy)
            state_r <= ST_VECT;
        end
        ST_VECT: begin
          // Domain fabric may come back, processors stay held.
          if (tgtPs) begin
            psResetN <= 1'b1;
            fpdResetN <= 1'b1;
          end else if (tgt_r == `SRS_TGT_FPD) begin
            fpdResetN <= 1'b1;
          end
          if (vectorOk)
            state_r <= ST_REL1;
        end
        ST_REL1: begin
          // Realtime cores first, then application cores.
          if (relRt(tgt_r))
            rpuCoreResetN <= 2'h3;
          state_r <= ST_REL2;
        end
        ST_REL2: begin
          if (relApp(tgt_r))
            apuCoreResetN <= 4'hf;
          else if (tgt_r == `SRS_TGT_ACORE)
            apuCoreResetN <= apuCoreResetN | mask_r;
          blockNewTxn <= 1'b0;
          platformErrToPl <= 1'b0;
          errToLpd <= 1'b0;
          fromErr_r <= 1'b0;
          reqBusy <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // srs_sequencer

// [verif/srs_seq_props.sv]
// Port assertions for the subsystem reset sequencer.
`timescale 1ns/1ps
module srs_seq_props (
  input wire core_clk,
  input wire reset_n,
  input wire lockstepMode,
  input wire quadSerial24Boot,
  input wire drainDone,
  input wire vectorOk,
  input wire [3:0] plResetReq,
  input wire reqRefused,
  input wire blockNewTxn,
  input wire psResetN,
  input wire fpdResetN,
  input wire [3:0] apuCoreResetN,
  input wire [1:0] rpuCoreResetN,
  input wire [3:0] plResetN,
  input wire platformErrToPl,
  input wire errToLpd
);
  // ----------------------------------------
  // Hold counter and properties
  // ----------------------------------------
  // Starts at 8 so the power-on release already meets the minimum.
  reg [3:0] lowCnt_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      lowCnt_r <= 4'h8;
    else if (rpuCoreResetN[0])
      lowCnt_r <= 4'h0;
    else if (lowCnt_r != 4'hf)
      lowCnt_r <= lowCnt_r + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_rt_drained: assert property ($fell(rpuCoreResetN[0]) |->
    $past(drainDone) && blockNewTxn) else $error("core reset undrained");
  chk_fpd_drained: assert property ($fell(fpdResetN) |->
    $past(drainDone)) else $error("domain reset undrained");
  chk_hold_min: assert property ($rose(rpuCoreResetN[0]) |->
    lowCnt_r >= 4'h8) else $error("reset hold too short");
  chk_vector_gate: assert property ($rose(rpuCoreResetN[0]) |->
    $past(vectorOk)) else $error("core released without vector");
  chk_release_order: assert property ($rose(apuCoreResetN[0]) |->
    &rpuCoreResetN) else $error("release order wrong");
  chk_lockstep_pair: assert property ($fell(rpuCoreResetN[0]) &&
    lockstepMode |-> !rpuCoreResetN[1]) else $error("lockstep pair");
  chk_refuse_boot: assert property (reqRefused |->
    quadSerial24Boot && psResetN && &apuCoreResetN) else $error("refusal");
  chk_error_both: assert property (errToLpd |->
    platformErrToPl) else $error("domain error not sent to logic");
  chk_pl_follow: assert property ($rose(plResetReq[0]) |->
    ##[1:8] !plResetN[0]) else $error("logic reset not driven");
  chk_pl_kept: assert property ($fell(psResetN) |->
    $stable(plResetN)) else $error("logic reset disturbed");
endmodule // srs_seq_props

// [verif/srs_far_model.sv]
// Interconnect drain responder and reset-vector loader model.
`timescale 1ns/1ps
module srs_far_model (
  input wire core_clk,
  input wire reset_n,
  input wire drainReq,
  input wire [7:0] resetsN,
  output reg drainDone,
  output reg vectorOk
);
  // ----------------------------------------
  // Slow answers: drain stalls, code reload takes 12 cycles
  // ----------------------------------------
  reg [1:0] drainCnt_r;
  reg [3:0] loadCnt_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      drainCnt_r <= 2'h0;
      loadCnt_r <= 4'h0;
      drainDone <= 1'b0;
      vectorOk <= 1'b0;
    end else begin
      drainCnt_r <= drainReq ? drainCnt_r + {1'b0, drainCnt_r != 2'h3} : 2'h0;
      drainDone <= drainReq && drainCnt_r == 2'h3;
      if (&resetsN)
        loadCnt_r <= 4'h0;
      else if (loadCnt_r != 4'hc)
        loadCnt_r <= loadCnt_r + 4'h1;
      vectorOk <= !(&resetsN) && loadCnt_r == 4'hc;
    end
  end
endmodule // srs_far_model

// [verif/tb_top.sv]
// Self-checking bench for the subsystem reset sequencer.
`timescale 1ns/1ps
module tb_top;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg reqValid = 1'b0;
  reg [2:0] reqTarget = 3'h0;
  reg [3:0] reqCoreMask = 4'h0;
  reg [5:0] errIn = 6'h00;
  reg lockstepErr = 1'b0;
  reg lockstepMode = 1'b0;
  reg watchdogTimeout = 1'b0;
  reg quadSerial24Boot = 1'b0;
  reg dualParallel = 1'b0;
  reg [15:0] flashSizeMb = 16'h0010;
  reg [3:0] plResetReq = 4'h0;
  wire drainDone, vectorOk, reqBusy, reqRefused, drainReq, blockNewTxn;
  wire psResetN, fpdResetN, platformErrToPl, errToLpd;
  wire [3:0] apuCoreResetN;
  wire [3:0] plResetN;
  wire [1:0] rpuCoreResetN;
  integer err_count = 0;
  integer tests_run = 0;
  integer cycles = 0;
  reg [16:0] seen = 17'h0;
  always #12.5 core_clk = ~core_clk;
  srs_sequencer i_dut (.core_clk, .reset_n, .reqValid, .reqTarget,
    .reqCoreMask, .errIn, .lockstepErr, .lockstepMode, .watchdogTimeout,
    .quadSerial24Boot, .dualParallel, .flashSizeMb, .drainDone, .vectorOk,
    .plResetReq, .reqBusy, .reqRefused, .drainReq, .blockNewTxn, .psResetN,
    .fpdResetN, .apuCoreResetN, .rpuCoreResetN, .plResetN,
    .platformErrToPl, .errToLpd);
  srs_far_model i_far (.core_clk, .reset_n, .drainReq, .drainDone,
    .vectorOk, .resetsN({psResetN, fpdResetN, rpuCoreResetN, apuCoreResetN}));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task req(input [2:0] t, input [3:0] m);
    begin
      @(negedge core_clk);
      reqTarget = t;
      reqCoreMask = m;
      reqValid = 1'b1;
      @(negedge core_clk);
      reqValid = 1'b0;
    end
  endtask
  // Gathers every active level until the sequence ends, then compares.
  task watch(input [16:0] exp, input [16:0] care);
    integer n;
    begin
      seen = 17'h0;
      // Sample first: a refusal pulse ends at the first rising edge after entry.
      for (n = 0; n < 400 && (n < 8 || reqBusy !== 1'b0); n = n + 1) begin
        seen = seen | {drainReq, reqBusy, reqRefused, errToLpd,
          platformErrToPl, ~plResetN, ~fpdResetN, ~psResetN,
          ~rpuCoreResetN, ~apuCoreResetN};
        @(negedge core_clk);
      end
      tests_run = tests_run + 1;
      if ((seen & care) !== (exp & care)) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task check_flag(input got, input expv);
    begin
      tests_run = tests_run + 1;
      if (got !== expv) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: flag %b expected %b", $time, got, expv);
      end
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_power;
    integer n;
    begin
      for (n = 0; n < 200 && !(&{psResetN, rpuCoreResetN, apuCoreResetN}
        && reqBusy === 1'b0); n = n + 1)
        @(negedge core_clk);
      watch(17'h00000, 17'h1ffff);
    end
  endtask
  task t_realtime;
    begin
      req(3'h3, 4'h0);
      check_flag(blockNewTxn, 1'b1);
      watch(17'h18010, 17'h1ffff);
      check_flag(blockNewTxn, 1'b0);
      req(3'h4, 4'h0);
      watch(17'h18020, 17'h1ffff);
      lockstepMode = 1'b1;
      req(3'h3, 4'h0);
      watch(17'h18030, 17'h1ffff);
      lockstepErr = 1'b1;
      watch(17'h18030, 17'h1ffff);
      lockstepErr = 1'b0;
      lockstepMode = 1'b0;
    end
  endtask
  task t_app;
    begin
      req(3'h5, 4'h5);
      watch(17'h08005, 17'h1ffff);
      watchdogTimeout = 1'b1;
      watch(17'h0800f, 17'h1ffff);
      watchdogTimeout = 1'b0;
    end
  endtask
  task t_procsys;
    begin
      req(3'h0, 4'h0);
      watch(17'h180ff, 17'h1ffff);
      errIn = 6'h01;
      watch(17'h190ff, 17'h1dfff);
      errIn = 6'h00;
    end
  endtask
  task t_domain;
    begin
      req(3'h1, 4'h0);
      watch(17'h18080, 17'h1fff0);
      errIn = 6'h04;
      watch(17'h1b080, 17'h1fff0);
      errIn = 6'h00;
    end
  endtask
  task t_boot;
    begin
      quadSerial24Boot = 1'b1;
      flashSizeMb = 16'h0011;
      req(3'h0, 4'h0);
      watch(17'h04000, 17'h17fff);
      dualParallel = 1'b1;
      flashSizeMb = 16'h0021;
      req(3'h2, 4'h0);
      watch(17'h04000, 17'h17fff);
      flashSizeMb = 16'h0020;
      req(3'h2, 4'h0);
      watch(17'h0800f, 17'h1ffff);
      quadSerial24Boot = 1'b0;
      dualParallel = 1'b0;
    end
  endtask
  task t_logic;
    begin
      @(negedge core_clk);
      plResetReq = 4'h3;
      watch(17'h00300, 17'h1ffff);
      plResetReq = 4'h0;
      repeat (12) @(negedge core_clk);
    end
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  initial begin
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    t_power;
    t_realtime;
    t_app;
    t_procsys;
    t_domain;
    t_boot;
    t_logic;
    conclude;
  end
endmodule // tb_top
bind srs_sequencer srs_seq_props i_props (.core_clk, .reset_n,
  .lockstepMode, .quadSerial24Boot, .drainDone, .vectorOk, .plResetReq,
  .reqRefused, .blockNewTxn, .psResetN, .fpdResetN, .apuCoreResetN,
  .rpuCoreResetN, .plResetN, .platformErrToPl, .errToLpd);
